// [common/rucc_pkg.sv]
package rucc_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WDOG = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_CAUSE = 8'h10;
   localparam logic [7:0] ADDR_IRQ = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam int PAGE_W = 3;
   localparam logic [2:0] FACTORY_PAGE = 3'h0;
   localparam int WDOG_W = 24;
   localparam logic [23:0] WDOG_RESET = 24'hFFFFFF;
   localparam int CMD_RELOAD = 0;
   localparam int CMD_WDOG_KICK = 1;
   localparam int CMD_PROG = 2;
   localparam int IRQ_WDOG = 0;
   localparam int IRQ_LOADERR = 1;
   localparam int IRQ_DONE = 2;
   localparam int IRQ_PROGERR = 3;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_WDOG = 2'b01,
      CAUSE_LOADERR = 2'b10,
      CAUSE_RELOAD = 2'b11
   } rucc_cause_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_FACTORY = 2'b10,
      ST_USER = 2'b11
   } rucc_state_t;

   typedef struct packed {
      logic req;
      logic [2:0] page;
      logic prog;
   } rucc_store_req_t;
endpackage

// [rtl/rucc_ctrl.sv]
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
module rucc_ctrl
   import rucc_pkg::*;
#(
   parameter int WDOG_WIDTH = WDOG_W
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Mode strap and configuration store
   input wire logic local_mode,
   input wire logic load_done,
   input wire logic load_err,
   output rucc_store_req_t store_req,
   // Status and interrupt
   output logic user_mode,
   output logic irq
);
   logic mode_s1_reg, mode_s2_reg;
   logic done_s1_reg, done_s2_reg;
   logic err_s1_reg, err_s2_reg;
   logic boot_s1_reg, boot_s2_reg;
   logic wr_pend_reg, rd_pend_reg;
   logic [7:0] addr_reg;
   rucc_state_t state_reg;
   logic active_factory_reg;
   logic [PAGE_W-1:0] next_page_reg;
   logic [PAGE_W-1:0] cur_page_reg;
   logic wdog_en_reg;
   logic [WDOG_WIDTH-1:0] wdog_load_reg;
   logic [WDOG_WIDTH-1:0] wdog_cnt_reg;
   rucc_cause_t cause_reg;
   logic [3:0] irq_stat_reg, irq_mask_reg;
   logic [31:0] hrdata_reg;
   logic irq_reg;
   logic user_reg;
   rucc_store_req_t store_reg;
   logic wr_ctrl, wr_wdog, wr_cmd, wr_irq, wr_mask, rd_cause;
   logic wdog_expire, load_ok, load_bad, reload_req, prog_bad, start;
   logic [3:0] irq_event;

   // Inputs from the store are asynchronous
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         err_s1_reg <= 1'b0;
         err_s2_reg <= 1'b0;
         boot_s1_reg <= 1'b0;
         boot_s2_reg <= 1'b0;
      end else begin
         // Boot flag holds the first load until the strap has crossed the sync
         boot_s1_reg <= 1'b1;
         boot_s2_reg <= boot_s1_reg;
         mode_s1_reg <= local_mode;
         mode_s2_reg <= mode_s1_reg;
         done_s1_reg <= load_done;
         done_s2_reg <= done_s1_reg;
         err_s1_reg <= load_err;
         err_s2_reg <= err_s1_reg;
      end
   end

   // Bus address phase, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         rd_pend_reg <= hsel && htrans[1] && !hwrite;
         addr_reg <= haddr;
      end
   end

   assign wr_ctrl = wr_pend_reg && addr_reg == ADDR_CTRL;
   assign wr_wdog = wr_pend_reg && addr_reg == ADDR_WDOG;
   assign wr_cmd = wr_pend_reg && addr_reg == ADDR_CMD;
   assign wr_irq = wr_pend_reg && addr_reg == ADDR_IRQ;
   assign wr_mask = wr_pend_reg && addr_reg == ADDR_MASK;
   assign rd_cause = rd_pend_reg && addr_reg == ADDR_CAUSE;
   assign start = state_reg == ST_IDLE && boot_s2_reg;
   assign load_ok = state_reg == ST_LOAD && done_s2_reg;
   assign load_bad = state_reg == ST_LOAD && err_s2_reg;
   assign reload_req = state_reg == ST_USER && wr_cmd && hwdata[CMD_RELOAD];
   assign wdog_expire = state_reg == ST_USER && wdog_en_reg && wdog_cnt_reg == '0;
   assign prog_bad = wr_cmd && hwdata[CMD_PROG] && next_page_reg == FACTORY_PAGE;

   // Load sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         cur_page_reg <= FACTORY_PAGE;
         active_factory_reg <= 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg <= ST_LOAD;
                  cur_page_reg <= mode_s2_reg ? next_page_reg : FACTORY_PAGE;
                  active_factory_reg <= !mode_s2_reg;
               end
            end
            ST_LOAD: begin
               if (err_s2_reg) begin
                  cur_page_reg <= FACTORY_PAGE;
                  active_factory_reg <= 1'b1;
                  state_reg <= ST_LOAD;
               end else if (done_s2_reg) begin
                  state_reg <= active_factory_reg ? ST_FACTORY : ST_USER;
               end
            end
            ST_FACTORY: begin
               if (wr_cmd && hwdata[CMD_RELOAD] && next_page_reg != FACTORY_PAGE) begin
                  cur_page_reg <= next_page_reg;
                  active_factory_reg <= 1'b0;
                  state_reg <= ST_LOAD;
               end
            end
            ST_USER: begin
               if (wdog_expire || reload_req) begin
                  cur_page_reg <= FACTORY_PAGE;
                  active_factory_reg <= 1'b1;
                  state_reg <= ST_LOAD;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Configuration registers; next page writable from any image, watchdog settings only from the factory image
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         next_page_reg <= FACTORY_PAGE;
         wdog_en_reg <= 1'b0;
         wdog_load_reg <= WDOG_WIDTH'(WDOG_RESET);
      end else begin
         if (wr_ctrl) begin
            next_page_reg <= hwdata[PAGE_W-1:0];
         end
         if (wr_wdog && state_reg == ST_FACTORY) begin
            wdog_en_reg <= hwdata[31];
            wdog_load_reg <= hwdata[WDOG_WIDTH-1:0];
         end
      end
   end

   // Watchdog
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdog_cnt_reg <= WDOG_WIDTH'(WDOG_RESET);
      end else if (state_reg != ST_USER || (wr_cmd && hwdata[CMD_WDOG_KICK])) begin
         wdog_cnt_reg <= wdog_load_reg;
      end else if (wdog_en_reg && wdog_cnt_reg != '0) begin
         wdog_cnt_reg <= wdog_cnt_reg - 1'b1;
      end
   end

   // Cause kept until read; new events win over the read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_reg <= CAUSE_NONE;
      end else if (wdog_expire) begin
         cause_reg <= CAUSE_WDOG;
      end else if (load_bad && !active_factory_reg) begin
         cause_reg <= CAUSE_LOADERR;
      end else if (reload_req) begin
         cause_reg <= CAUSE_RELOAD;
      end else if (rd_cause) begin
         cause_reg <= CAUSE_NONE;
      end
   end

   assign irq_event = {prog_bad, load_ok, load_bad, wdog_expire};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_event | (irq_stat_reg & ~(wr_irq ? hwdata[3:0] : 4'h0));
         if (wr_mask) begin
            irq_mask_reg <= hwdata[3:0];
         end
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         store_reg <= '0;
         user_reg <= 1'b0;
      end else begin
         store_reg.req <= start || load_ok ? 1'b0 : state_reg == ST_LOAD;
         store_reg.page <= wr_cmd && hwdata[CMD_PROG] ? next_page_reg : cur_page_reg;
         store_reg.prog <= wr_cmd && hwdata[CMD_PROG] && !prog_bad;
         user_reg <= state_reg == ST_USER;
      end
   end

   // Read data registered from the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr)
            ADDR_CTRL: hrdata_reg <= {29'h0, next_page_reg};
            ADDR_WDOG: hrdata_reg <= {wdog_en_reg, 7'h0, 24'(wdog_load_reg)};
            ADDR_STAT: hrdata_reg <= {27'h0, mode_s2_reg, active_factory_reg,
                                      cur_page_reg};
            ADDR_CAUSE: hrdata_reg <= {30'h0, cause_reg};
            ADDR_IRQ: hrdata_reg <= {28'h0, irq_stat_reg};
            ADDR_MASK: hrdata_reg <= {28'h0, irq_mask_reg};
            default: hrdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = irq_reg;
   assign user_mode = user_reg;
   assign store_req = store_reg;

   wdog_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_FACTORY |=> wdog_cnt_reg == $past(wdog_load_reg))
      else $error("watchdog active in factory");

   sequence s_expire;
      wdog_expire;
   endsequence
   wdog_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_expire |=> state_reg == ST_LOAD && cur_page_reg == FACTORY_PAGE
                   && cause_reg == CAUSE_WDOG)
      else $error("expiry did not reload factory");

   load_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
      load_bad && !active_factory_reg && !wdog_expire |=>
         cause_reg == CAUSE_LOADERR && active_factory_reg)
      else $error("load failure not recorded");

   load_user_a: assert property (@(posedge hclk) disable iff (!hresetn)
      load_ok && !err_s2_reg && !active_factory_reg |=> state_reg == ST_USER ##1 user_mode)
      else $error("user mode not entered");

   power_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start && !mode_s2_reg |=> cur_page_reg == FACTORY_PAGE && active_factory_reg)
      else $error("remote start not factory page");

   local_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start && mode_s2_reg |=> !active_factory_reg)
      else $error("local start loaded factory");

   factory_safe_a: assert property (@(posedge hclk) disable iff (!hresetn)
      store_req.prog |-> store_req.page != FACTORY_PAGE)
      else $error("factory page programmed");

   cause_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cause_reg != CAUSE_NONE && !rd_cause && !wdog_expire && !load_bad && !reload_req
         |=> $stable(cause_reg))
      else $error("cause lost before read");

   factory_launch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_FACTORY && wr_cmd && hwdata[CMD_RELOAD] && next_page_reg != 3'h0
         |=> state_reg == ST_LOAD && cur_page_reg == $past(next_page_reg))
      else $error("next page not launched");

   wdog_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_wdog && state_reg != ST_FACTORY |=> $stable(wdog_en_reg) && $stable(wdog_load_reg))
      else $error("watchdog written outside factory");

   wdog_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_USER && wdog_en_reg && wdog_cnt_reg != '0 && !wr_cmd
         |=> wdog_cnt_reg == $past(wdog_cnt_reg) - 1'b1)
      else $error("watchdog did not count");

   user_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_USER |=> user_mode)
      else $error("user flag missing");

   page_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> next_page_reg == $past(hwdata[PAGE_W-1:0]))
      else $error("next page not written");

   prog_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      prog_bad |=> irq_stat_reg[IRQ_PROGERR] && !store_req.prog)
      else $error("factory program not refused");

   retry_factory_a: assert property (@(posedge hclk) disable iff (!hresetn)
      load_bad |=> state_reg == ST_LOAD && cur_page_reg == FACTORY_PAGE)
      else $error("load error did not retry factory");

   local_page_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start && mode_s2_reg |=> cur_page_reg == $past(next_page_reg))
      else $error("local start wrong page");
endmodule

// [tb/rucc_store_model.sv]
module rucc_store_model
   import rucc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Store link
   input wire rucc_store_req_t store_req,
   input wire logic [7:0] bad_mask,
   output logic load_done,
   output logic load_err,
   output logic [7:0] prog_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow;
   initial begin
      load_done = 1'h0;
      load_err = 1'h0;
      prog_seen = 8'h00;
      slow = 1'h0;
   end
   always @(posedge hclk) begin
      if (store_req.prog === 1'h1) begin
         prog_seen[store_req.page] <= 1'h1;
      end
   end
   // paged load, corrupt page answers error
   initial forever begin
      @(posedge hclk);
      if (hresetn === 1'h1 && store_req.req === 1'h1) begin
         repeat (slow ? 12 : 1) @(posedge hclk);
         load_done <= ~bad_mask[store_req.page];
         load_err <= bad_mask[store_req.page];
         // Level held long enough for the two-flop sync; a retry keeps req up
         repeat (3) @(posedge hclk);
         load_done <= 1'h0;
         load_err <= 1'h0;
         slow = ~slow;
      end
   end
endmodule

// [tb/rucc_ctrl_tb_top.sv]
module rucc_ctrl_tb_top
   import rucc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } rucc_row_t;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic local_mode, load_done, load_err, user_mode, irq;
   logic [7:0] haddr, bad_mask, prog_seen;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r;
   rucc_store_req_t store_req;
   int n_fail = 0;
   int checked = 0;
   int i;
   rucc_row_t rows [8] = '{'{1'h0, ADDR_STAT, 32'h0, 32'h8}, '{1'h0, ADDR_CTRL, 32'h0, 32'h0},
      '{1'h0, ADDR_CAUSE, 32'h0, 32'h0}, '{1'h1, ADDR_CTRL, 32'hFF, 32'h7},
      '{1'h1, ADDR_IRQ, 32'hF, 32'h0}, '{1'h1, 8'h1C, 32'hFFFFFFFF, 32'h0},
      '{1'h1, ADDR_CTRL, 32'h0, 32'h0}, '{1'h1, ADDR_MASK, 32'hF, 32'hF}};
   assign hready = hreadyout;
   rucc_ctrl #(.WDOG_WIDTH(8)) rucc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .local_mode(local_mode), .load_done(load_done), .load_err(load_err),
      .store_req(store_req), .user_mode(user_mode), .irq(irq));
   rucc_store_model rucc_store_model_i (.hclk(hclk), .hresetn(hresetn), .store_req(store_req),
      .bad_mask(bad_mask), .load_done(load_done), .load_err(load_err), .prog_seen(prog_seen));
   initial begin
      hclk = 1'h0;
      forever #4 hclk = ~hclk;
   end
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      r = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: %s got %h", $time, m, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(1'h0, a, 32'h0);
      chk(r, e, m);
   endtask
   // Polls state; factory counts only once the store is idle
   task automatic waitfor(input logic usr);
      int k;
      repeat (2) @(posedge hclk);
      for (k = 0; k < 400; k++) begin
         bus(1'h0, ADDR_STAT, 32'h0);
         if (usr ? user_mode === 1'h1 : (r[3] === 1'h1 && store_req.req === 1'h0 &&
            user_mode === 1'h0)) break;
      end
      chk({31'h0, k < 400}, 32'h1, "state not reached");
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge hclk);
      n_fail++;
      $display("wrong value at %0t ns: run hung", $time);
      test_done;
   end
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, local_mode, bad_mask} = '0;
      hsize = 3'h2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      waitfor(1'h0);
      foreach (rows[k]) begin
         if (rows[k].wr) bus(1'h1, rows[k].a, rows[k].d);
         rd(rows[k].a, rows[k].e, "register row");
      end
      $display("test registers done");
      for (int p = 1; p < 8; p++) begin
         bus(1'h1, ADDR_CTRL, 32'(p));
         bus(1'h1, ADDR_CMD, 32'h1);
         waitfor(1'h1);
         rd(ADDR_STAT, 32'(p), "app page");
         bus(1'h1, ADDR_CMD, 32'h1);
         waitfor(1'h0);
         rd(ADDR_CAUSE, 32'h3, "reload cause");
      end
      $display("test pages done");
      bad_mask <= 8'h20;
      bus(1'h1, ADDR_CTRL, 32'h5);
      bus(1'h1, ADDR_CMD, 32'h1);
      for (i = 0; i < 200 && load_err !== 1'h1; i++) @(posedge hclk);
      waitfor(1'h0);
      rd(ADDR_CAUSE, 32'h2, "load error cause");
      bus(1'h0, ADDR_IRQ, 32'h0);
      chk({31'h0, r[1]}, 32'h1, "load error status");
      chk({31'h0, irq}, 32'h1, "irq raised");
      bus(1'h1, ADDR_MASK, 32'h0);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      bus(1'h1, ADDR_MASK, 32'hF);
      bus(1'h1, ADDR_IRQ, 32'hF);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      bus(1'h1, ADDR_CTRL, 32'h6);
      bus(1'h1, ADDR_CMD, 32'h1);
      waitfor(1'h1);
      rd(ADDR_STAT, 32'h6, "recovered page");
      bus(1'h1, ADDR_CMD, 32'h1);
      waitfor(1'h0);
      rd(ADDR_CAUSE, 32'h3, "reload cause");
      $display("test fallback done");
      bus(1'h1, ADDR_WDOG, 32'h80000014);
      bus(1'h1, ADDR_CTRL, 32'h2);
      bus(1'h1, ADDR_CMD, 32'h1);
      waitfor(1'h1);
      bus(1'h1, ADDR_WDOG, 32'h00000000);
      repeat (6) begin
         repeat (8) @(posedge hclk);
         bus(1'h1, ADDR_CMD, 32'h2);
      end
      chk({31'h0, user_mode}, 32'h1, "kicked app alive");
      waitfor(1'h0);
      rd(ADDR_CAUSE, 32'h1, "watchdog cause");
      rd(ADDR_CAUSE, 32'h0, "cause read clears");
      repeat (60) @(posedge hclk);
      rd(ADDR_STAT, 32'h8, "factory kept");
      $display("test watchdog done");
      bus(1'h1, ADDR_CTRL, 32'h0);
      bus(1'h1, ADDR_CMD, 32'h4);
      bus(1'h0, ADDR_IRQ, 32'h0);
      chk({31'h0, r[3]}, 32'h1, "refused program");
      bus(1'h1, ADDR_CTRL, 32'h3);
      bus(1'h1, ADDR_CMD, 32'h4);
      repeat (3) @(posedge hclk);
      chk({24'h0, prog_seen}, 32'h8, "programmed pages");
      $display("test program done");
      local_mode <= 1'h1;
      @(posedge hclk);
      hresetn <= 1'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      waitfor(1'h1);
      rd(ADDR_STAT, 32'h10, "local app");
      $display("test local done");
      test_done;
   end
endmodule
